// ### design/arbf_top.sv
// Result bus formatter with register slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - Width 0 drives all 18 bits straight
// - Width 1 high word on lines 2-17
// - Width 1 low word, lines 2-3, rest zero
// - Width 2 high byte on lines 10-17
// - Width 2 midbyte bits 2-9 on 10-17
// - Width 2 low byte on 16-17 with line 2 high, else on 10-11; rest zero
// - Serial software mode uses register configuration
// - Bus enabled only with select and read low
// - Reset clears configuration and output data
module arbf_top (
	input  wire logic                    clk_sys_i,
	input  wire logic                    sys_rst_i,
	input  wire logic [17:0]             result_i,
	input  wire logic                    result_load_i,
	input  wire logic                    bus_width_select_msb_i,
	input  wire logic                    bus_width_select_lsb_i,
	input  wire logic                    cs_n_i,
	input  wire logic                    rd_n_i,
	input  wire logic [17:0]             data_i,
	output logic      [17:0]             data_o,
	output logic      [17:0]             data_oe_o,
	input  wire logic                    hardware_software_select_i,
	input  wire logic [1:0]              range_pin_i,
	input  wire logic [1:0]              conv_mode_pin_i,
	output logic      [1:0]              eff_range_o,
	output logic      [1:0]              eff_conv_mode_o,
	input  wire logic                    internal_ref_powerdown_i,
	input  wire logic                    ref_buffer_powerdown_i,
	output logic                         int_ref_enable_o,
	output logic                         ref_buffer_enable_o,
	input  wire logic [3:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic      [1:0]              s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [3:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic      [31:0]             s_axi_rdata,
	output logic      [1:0]              s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready
);
	// ****************************************
	// Internal state
	// ****************************************
	logic [17:0]                  result_r;
	logic [arbf_pkg::CFG_W-1:0]   cfg_r;
	logic [17:0]                  data_r;
	logic [17:0]                  oe_r;
	logic [17:0]                  data_nxt;
	logic [17:0]                  oe_nxt;
	logic [17:0]                  fmt_w;
	logic [1:0]                   bw_w;
	logic                         en_w;
	logic                         twoc_w;
	logic [1:0]                   range_r;
	logic [1:0]                   cmode_r;
	logic                         iref_r;
	logic                         buf_r;
	logic                         aw_hold_r;
	logic                         w_hold_r;
	logic [3:0]                   awaddr_r;
	logic [31:0]                  wdata_r;
	logic                         wstrb0_r;
	logic                         awready_r;
	logic                         wready_r;
	logic                         bvalid_r;
	logic [1:0]                   bresp_r;
	logic                         arready_r;
	logic                         rvalid_r;
	logic [31:0]                  rdata_r;
	logic [1:0]                   rresp_r;
	logic                         wr_go_w;

	assign bw_w = {bus_width_select_msb_i, bus_width_select_lsb_i};
	assign en_w = !cs_n_i && !rd_n_i;

	// Line 0 is the format input in every mode but 18-bit parallel
	assign twoc_w = (bw_w == arbf_pkg::BW_PAR18) ?
		cfg_r[arbf_pkg::CFG_TWOC_BIT] : !data_i[0];
	assign fmt_w = twoc_w ? {~result_r[17], result_r[16:0]} : result_r;

	// ****************************************
	// Result capture
	// ****************************************
	// reset clears the captured result
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			result_r <= arbf_pkg::RES_RST;
		end else if (result_load_i) begin
			result_r <= result_i;
		end
	end

	// ****************************************
	// Data bus lane steering
	// ****************************************
	always_comb begin
		data_nxt = arbf_pkg::ALL_OFF;
		oe_nxt   = arbf_pkg::ALL_OFF;
		case (bw_w)
			arbf_pkg::BW_PAR18: begin
				data_nxt = fmt_w;
				oe_nxt   = arbf_pkg::ALL_ON;
			end
			arbf_pkg::BW_WORD16: begin
				oe_nxt = {16'hFFFF, 2'h0};
				if (!data_i[1]) begin
					data_nxt[17:2] = fmt_w[17:2];
				end else begin
					data_nxt[3:2] = fmt_w[1:0];
				end
			end
			arbf_pkg::BW_BYTE8: begin
				// Lines 3 to 9 stay released in byte mode
				oe_nxt = {8'hFF, 10'h000};
				case ({data_i[1], data_i[2]})
					2'h0: data_nxt[17:10] = fmt_w[17:10];
					2'h1: data_nxt[17:10] = fmt_w[9:2];
					// Low bits on lines 10 and 11
					2'h2: data_nxt[11:10] = fmt_w[1:0];
					// low bits on 16 and 17
					default: data_nxt[17:16] = fmt_w[1:0];
				endcase
			end
			default: begin
				oe_nxt = arbf_pkg::ALL_OFF;
			end
		endcase
		if (!en_w) begin
			oe_nxt = arbf_pkg::ALL_OFF;
		end
		data_nxt = data_nxt & oe_nxt;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			data_r <= arbf_pkg::ALL_OFF;
			oe_r   <= arbf_pkg::ALL_OFF;
		end else begin
			data_r <= data_nxt;
			oe_r   <= oe_nxt;
		end
	end

	// ****************************************
	// Effective configuration and reference
	// ****************************************
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			range_r <= 2'h0;
			cmode_r <= 2'h0;
			iref_r  <= 1'b0;
			buf_r   <= 1'b0;
		end else begin
			if (bw_w == arbf_pkg::BW_SERIAL &&
			    !hardware_software_select_i) begin
				range_r <= cfg_r[arbf_pkg::CFG_RANGE_LSB +: 2];
				cmode_r <= cfg_r[arbf_pkg::CFG_CMODE_LSB +: 2];
			end else begin
				range_r <= range_pin_i;
				cmode_r <= conv_mode_pin_i;
			end
			iref_r <= !internal_ref_powerdown_i;
			buf_r  <= !ref_buffer_powerdown_i;
		end
	end

	// ****************************************
	// Register slave, write path
	// ****************************************
	// Address and data may arrive in either order
	assign wr_go_w = aw_hold_r && w_hold_r && !bvalid_r;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_hold_r <= 1'b0;
			awready_r <= 1'b1;
			awaddr_r  <= 4'h0;
		end else if (s_axi_awvalid && awready_r) begin
			aw_hold_r <= 1'b1;
			awready_r <= 1'b0;
			awaddr_r  <= s_axi_awaddr;
		end else if (bvalid_r && s_axi_bready) begin
			aw_hold_r <= 1'b0;
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			w_hold_r <= 1'b0;
			wready_r <= 1'b1;
			wdata_r  <= 32'h00000000;
			wstrb0_r <= 1'b0;
		end else if (s_axi_wvalid && wready_r) begin
			w_hold_r <= 1'b1;
			wready_r <= 1'b0;
			wdata_r  <= s_axi_wdata;
			wstrb0_r <= s_axi_wstrb[0];
		end else if (bvalid_r && s_axi_bready) begin
			w_hold_r <= 1'b0;
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bvalid_r <= 1'b0;
			bresp_r  <= arbf_pkg::RESP_OKAY;
		end else if (wr_go_w) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (awaddr_r[3:2] <= arbf_pkg::RESULT_OFS[3:2]) ?
				arbf_pkg::RESP_OKAY : arbf_pkg::RESP_DECERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_r <= arbf_pkg::CFG_RST;
		end else if (wr_go_w && wstrb0_r &&
		             awaddr_r[3:2] == arbf_pkg::CFG_OFS[3:2]) begin
			cfg_r <= wdata_r[arbf_pkg::CFG_W-1:0];
		end
	end

	// ****************************************
	// Register slave, read path
	// ****************************************
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= arbf_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= arbf_pkg::RESP_OKAY;
			rdata_r   <= 32'h00000000;
			case (s_axi_araddr[3:2])
				arbf_pkg::CFG_OFS[3:2]: begin
					rdata_r[arbf_pkg::CFG_W-1:0] <= cfg_r;
				end
				arbf_pkg::STATUS_OFS[3:2]: begin
					rdata_r[arbf_pkg::ST_RANGE_LSB +: 2] <= range_r;
					rdata_r[arbf_pkg::ST_CMODE_LSB +: 2] <= cmode_r;
					rdata_r[arbf_pkg::ST_BW_LSB +: 2]    <= bw_w;
					rdata_r[arbf_pkg::ST_EN_BIT]         <= en_w;
					rdata_r[arbf_pkg::ST_IREF_BIT]       <= iref_r;
					rdata_r[arbf_pkg::ST_BUF_BIT]        <= buf_r;
				end
				arbf_pkg::RESULT_OFS[3:2]: begin
					rdata_r[17:0] <= result_r;
				end
				default: begin
					rresp_r <= arbf_pkg::RESP_DECERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign data_o          = data_r;
	assign data_oe_o       = oe_r;
	assign eff_range_o     = range_r;
	assign eff_conv_mode_o = cmode_r;
	assign int_ref_enable_o    = iref_r;
	assign ref_buffer_enable_o = buf_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_word(logic a0);
		en_w && bw_w == arbf_pkg::BW_WORD16 && data_i[1] == a0;
	endsequence
	sequence s_byte(logic a0, logic a1);
		en_w && bw_w == arbf_pkg::BW_BYTE8 &&
		data_i[1] == a0 && data_i[2] == a1;
	endsequence

	property p_par18;
		en_w && bw_w == arbf_pkg::BW_PAR18 |=>
			oe_r == arbf_pkg::ALL_ON && data_r == $past(fmt_w);
	endproperty
	a_par18: assert property (p_par18)
		else $error("parallel 18-bit output wrong");

	property p_hiword;
		s_word(1'b0) |=> oe_r[1:0] == 2'h0 &&
			data_r[17:2] == $past(fmt_w[17:2]);
	endproperty
	a_hiword: assert property (p_hiword)
		else $error("high word output wrong");

	property p_loword;
		s_word(1'b1) |=> data_r[17:4] == 14'h0000 &&
			data_r[3:2] == $past(fmt_w[1:0]) && oe_r[17:2] == 16'hFFFF;
	endproperty
	a_loword: assert property (p_loword)
		else $error("low word output wrong");

	property p_hibyte;
		s_byte(1'b0, 1'b0) |=> oe_r[9:3] == 7'h00 &&
			data_r[17:10] == $past(fmt_w[17:10]);
	endproperty
	a_hibyte: assert property (p_hibyte)
		else $error("high byte output wrong");

	property p_midbyte;
		s_byte(1'b0, 1'b1) |=> oe_r[9:3] == 7'h00 &&
			data_r[17:10] == $past(fmt_w[9:2]);
	endproperty
	a_midbyte: assert property (p_midbyte)
		else $error("midbyte output wrong");

	property p_lobyte;
		s_byte(1'b1, 1'b1) |=> data_r[15:10] == 6'h00 &&
			data_r[17:16] == $past(fmt_w[1:0]) && oe_r[9:3] == 7'h00;
	endproperty
	a_lobyte: assert property (p_lobyte)
		else $error("low byte output wrong");

	property p_serial;
		bw_w == arbf_pkg::BW_SERIAL |=> oe_r == arbf_pkg::ALL_OFF;
	endproperty
	a_serial: assert property (p_serial)
		else $error("lines driven in serial mode");

	property p_swcfg;
		bw_w == arbf_pkg::BW_SERIAL && !hardware_software_select_i |=>
			range_r == $past(cfg_r[arbf_pkg::CFG_RANGE_LSB +: 2]) &&
			cmode_r == $past(cfg_r[arbf_pkg::CFG_CMODE_LSB +: 2]);
	endproperty
	a_swcfg: assert property (p_swcfg)
		else $error("register configuration not applied");

	property p_gate;
		oe_r != arbf_pkg::ALL_OFF |-> $past(en_w);
	endproperty
	a_gate: assert property (p_gate)
		else $error("bus driven without select and read");

	property p_release;
		!en_w [*2] |=> oe_r == arbf_pkg::ALL_OFF && data_r == 18'h00000;
	endproperty
	a_release: assert property (p_release)
		else $error("disabled bus not released");
endmodule

// ### shared/arbf_pkg.sv
// Constants shared by the result bus formatter
package arbf_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int unsigned RES_W  = 18;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;

	// ****************************************
	// Bus width selection codes
	// ****************************************
	localparam logic [1:0] BW_PAR18  = 2'h0;
	localparam logic [1:0] BW_WORD16 = 2'h1;
	localparam logic [1:0] BW_BYTE8  = 2'h2;
	localparam logic [1:0] BW_SERIAL = 2'h3;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [ADDR_W-1:0] CFG_OFS    = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] RESULT_OFS = 4'h8;

	// Configuration register fields
	localparam int unsigned CFG_RANGE_LSB = 0;
	localparam int unsigned CFG_CMODE_LSB = 2;
	localparam int unsigned CFG_TWOC_BIT  = 4;
	localparam int unsigned CFG_W         = 5;
	localparam logic [CFG_W-1:0] CFG_RST  = 5'h00;

	// Status register fields
	localparam int unsigned ST_RANGE_LSB = 0;
	localparam int unsigned ST_CMODE_LSB = 2;
	localparam int unsigned ST_BW_LSB    = 4;
	localparam int unsigned ST_EN_BIT    = 6;
	localparam int unsigned ST_IREF_BIT  = 7;
	localparam int unsigned ST_BUF_BIT   = 8;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	localparam logic [RES_W-1:0] RES_RST = 18'h00000;
	localparam logic [RES_W-1:0] ALL_ON  = 18'h3FFFF;
	localparam logic [RES_W-1:0] ALL_OFF = 18'h00000;
endpackage

// ### tb/arbf_host_model.sv
// Host reader model for the result bus formatter
`timescale 1ns/100ps
module arbf_host_model (
	input  wire logic       clk_sys_i,
	input  wire logic       rd_req_i,
	input  wire logic [2:0] sel_i,
	input  wire logic       iref_off_i,
	input  wire logic       buf_off_i,
	output logic            cs_n_o,
	output logic            rd_n_o,
	output logic      [2:0] sel_o,
	output logic            iref_pd_o,
	output logic            buf_pd_o
);
	always @(posedge clk_sys_i) begin
		cs_n_o <= ~rd_req_i;
		rd_n_o <= ~rd_req_i;
		sel_o <= sel_i;
	end
	// buffer kept on with internal ref
	always @(posedge clk_sys_i) begin
		iref_pd_o <= iref_off_i;
		buf_pd_o <= buf_off_i & iref_off_i;
	end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the result bus formatter
`timescale 1ns/100ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t ns: %s", $time, m); end end
module tb_top;
	typedef struct packed {
		logic [1:0]  bw;
		logic [2:0]  sel;
		logic [17:0] dat;
		logic [17:0] oe;
	} arbf_row_t;
	localparam logic [17:0] RES = 18'h3A5C3;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [17:0] result_i = 18'h00000;
	logic        result_load_i = 1'b0;
	logic [1:0]  bw = 2'h0;
	logic [17:0] data_i, data_o, data_oe_o;
	logic        cs_n, rd_n, rd_req = 1'b0, hardware_software_select = 1'b1;
	logic [2:0]  sel = 3'h1, host_sel;
	logic [1:0]  range_pin = 2'h0, cmode_pin = 2'h0, eff_range, eff_cmode;
	logic        iref_off = 1'b0, buf_off = 1'b0, iref_pd, buf_pd;
	logic        iref_en, buf_en;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          errors = 0;
	int          checked = 0;
	arbf_row_t   rows [9] = '{
		'{2'h0, 3'h1, 18'h3A5C3, 18'h3FFFF}, '{2'h1, 3'h1, 18'h3A5C0, 18'h3FFFC},
		'{2'h1, 3'h0, 18'h1A5C0, 18'h3FFFC}, '{2'h1, 3'h3, 18'h0000C, 18'h3FFFC},
		'{2'h2, 3'h1, 18'h3A400, 18'h3FC00}, '{2'h2, 3'h5, 18'h1C000, 18'h3FC00},
		'{2'h2, 3'h3, 18'h00C00, 18'h3FC00}, '{2'h2, 3'h7, 18'h30000, 18'h3FC00},
		'{2'h3, 3'h1, 18'h00000, 18'h00000}};
	// Undriven lines 3 to 17 read back high, never the last value; lines 0-2 carry the host select
	assign data_i = {data_o[17:3] | ~data_oe_o[17:3], host_sel};
	always #50 clk_sys_i = ~clk_sys_i;
	arbf_host_model u_arbf_host_model (.clk_sys_i(clk_sys_i), .rd_req_i(rd_req),
		.sel_i(sel), .iref_off_i(iref_off), .buf_off_i(buf_off), .cs_n_o(cs_n),
		.rd_n_o(rd_n), .sel_o(host_sel), .iref_pd_o(iref_pd), .buf_pd_o(buf_pd));
	arbf_top u_arbf_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.result_i(result_i), .result_load_i(result_load_i),
		.bus_width_select_msb_i(bw[1]), .bus_width_select_lsb_i(bw[0]),
		.cs_n_i(cs_n), .rd_n_i(rd_n), .data_i(data_i), .data_o(data_o),
		.data_oe_o(data_oe_o), .hardware_software_select_i(hardware_software_select),
		.range_pin_i(range_pin), .conv_mode_pin_i(cmode_pin),
		.eff_range_o(eff_range), .eff_conv_mode_o(eff_cmode),
		.internal_ref_powerdown_i(iref_pd), .ref_buffer_powerdown_i(buf_pd),
		.int_ref_enable_o(iref_en), .ref_buffer_enable_o(buf_en),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	// ****************************************
	// Tasks
	// ****************************************
	task finish_test;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task tmo;
		errors++;
		$display("wrong value at %0t ns: wait ran out", $time);
		finish_test();
	endtask
	// Host path adds one cycle ahead of the design
	task settle;
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask
	task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 20 && !(aw && w); n++) begin
			@(posedge clk_sys_i);
			aw = aw | (s_axi_awready === 1'b1);
			w = w | (s_axi_wready === 1'b1);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		if (!(aw && w))
			tmo();
		for (n = 0; n < 20 && s_axi_bvalid !== 1'b1; n++)
			@(posedge clk_sys_i);
		if (n == 20)
			tmo();
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ar;
		ar = 1'b0;
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// Address counts as taken only at an edge that sees ready high
		for (n = 0; n < 20 && !ar; n++) begin
			@(posedge clk_sys_i);
			ar = (s_axi_arready === 1'b1);
		end
		if (!ar)
			tmo();
		s_axi_arvalid <= 1'b0;
		for (n = 0; n < 20 && s_axi_rvalid !== 1'b1; n++)
			@(posedge clk_sys_i);
		if (n == 20)
			tmo();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_sys_i);
		`CHK(data_oe_o, 18'h00000, "oe after reset")
		@(posedge clk_sys_i);
		result_i <= RES;
		result_load_i <= 1'b1;
		@(posedge clk_sys_i);
		result_load_i <= 1'b0;
		rd_req <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk_sys_i);
			bw <= rows[i].bw;
			sel <= rows[i].sel;
			settle();
			`CHK(data_o, rows[i].dat, "bus data")
			`CHK(data_oe_o, rows[i].oe, "bus enables")
		end
		// Bus released once the host stops reading
		@(posedge clk_sys_i);
		bw <= arbf_pkg::BW_PAR18;
		rd_req <= 1'b0;
		settle();
		`CHK({data_o, data_oe_o}, 36'h0, "idle bus")
		// Every host power-down request combination; buffer power-down reaches the design only with the internal ref off
		for (int j = 0; j < 4; j++) begin
			@(posedge clk_sys_i);
			iref_off <= j[1];
			buf_off <= j[0];
			settle();
			`CHK({iref_en, buf_en}, {~j[1], ~(j[1] & j[0])}, "ref enables")
		end
		axi_wr(arbf_pkg::CFG_OFS, 32'h00000009, rsp);
		`CHK(rsp, arbf_pkg::RESP_OKAY, "config write")
		axi_wr(4'hC, 32'h0000001F, rsp);
		`CHK(rsp, arbf_pkg::RESP_DECERR, "unmapped write")
		axi_rd(4'hC, rd, rsp);
		`CHK({rsp, rd}, {arbf_pkg::RESP_DECERR, 32'h0}, "unmapped read")
		axi_rd(arbf_pkg::CFG_OFS, rd, rsp);
		`CHK(rd, 32'h00000009, "config kept")
		axi_rd(arbf_pkg::RESULT_OFS, rd, rsp);
		`CHK(rd, {14'h0, RES}, "result reg")
		// Serial software mode takes the register, not the pins
		@(posedge clk_sys_i);
		bw <= arbf_pkg::BW_SERIAL;
		hardware_software_select <= 1'b0;
		range_pin <= 2'h2;
		cmode_pin <= 2'h1;
		settle();
		`CHK({eff_range, eff_cmode}, 4'h6, "software config")
		axi_rd(arbf_pkg::STATUS_OFS, rd, rsp);
		`CHK(rd, 32'h00000039, "status")
		@(posedge clk_sys_i);
		hardware_software_select <= 1'b1;
		settle();
		`CHK({eff_range, eff_cmode}, 4'h9, "pin config")
		// Two's complement in full width from the register
		axi_wr(arbf_pkg::CFG_OFS, 32'h00000010, rsp);
		@(posedge clk_sys_i);
		bw <= arbf_pkg::BW_PAR18;
		rd_req <= 1'b1;
		settle();
		`CHK(data_o, RES ^ 18'h20000, "msb inverted")
		// Reset in mid-read clears data and config
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b1;
		@(negedge clk_sys_i);
		`CHK({data_o, data_oe_o}, 36'h0, "bus in reset")
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		axi_rd(arbf_pkg::CFG_OFS, rd, rsp);
		`CHK(rd, 32'h0, "config cleared")
		settle();
		`CHK({data_o, data_oe_o}, {18'h0, 18'h3FFFF}, "data cleared")
		finish_test();
	end
endmodule
